// ---- hw/ccpt_pkg.sv ----
`default_nettype none
package ccpt_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL_LO = 8'h00;
  localparam logic [7:0] REG_CTRL_HI = 8'h04;
  localparam logic [7:0] REG_CTRL2_HI = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_CNT_LO = 8'h10;
  localparam logic [7:0] REG_CNT_HI = 8'h14;
  localparam logic [7:0] REG_PER_LO = 8'h18;
  localparam logic [7:0] REG_PER_HI = 8'h1c;
  localparam logic [7:0] REG_CMP_A = 8'h20;
  localparam logic [7:0] REG_CMP_B = 8'h24;
  localparam logic [7:0] REG_CAP_LO = 8'h28;
  localparam logic [7:0] REG_CAP_HI = 8'h2c;
  // Control low field positions
  localparam int F_FUNC_LSB = 0;
  localparam int F_CAPSEL = 4;
  localparam int F_WIDE = 5;
  localparam int F_CLKSEL_LSB = 8;
  localparam int F_RESYNC = 11;
  localparam int F_ENABLE = 15;
  // Control high field positions
  localparam int F_SYNC_LSB = 0;
  localparam int F_TRIGGER_OPERATION_ENABLE = 7;
  // Control two high
  localparam int F_AUX_LSB = 3;
  // Status positions
  localparam int F_TRIGGER_CLEAR_REQUEST = 5;
  localparam int F_TRIGGED = 7;
  localparam int F_CAP_AVAIL = 0;
  localparam int F_CFG_BAD = 1;
  localparam int F_CAP_OVF = 2;
  // Encodings
  localparam logic [2:0] CLK_SYSTEM = 3'h0;
  localparam logic [4:0] SYNC_NONE = 5'h00;
  localparam logic [4:0] SYNC_AUTO_ROLL = 5'h1f;
  localparam logic [1:0] AUX_OFF = 2'h0;
  localparam logic [1:0] AUX_PERIOD = 2'h1;
  localparam logic [1:0] AUX_EVENT = 2'h2;
  localparam logic [1:0] AUX_SIGNAL = 2'h3;
  localparam int HALF_W = 16;
  localparam int FIFO_DEPTH = 4;

  typedef enum logic [3:0] {
    FN_TIMER = 4'b0000,
    FN_OC_HIGH = 4'b0001,
    FN_OC_LOW = 4'b0010,
    FN_OC_TOGGLE = 4'b0011,
    FN_DUAL_EDGE = 4'b0100,
    FN_DUAL_BUF = 4'b0101,
    FN_CENTER = 4'b0110,
    FN_VAR_FREQ = 4'b0111
  } ccpt_fn_t;

  typedef enum logic [3:0] {
    IC_EDGE = 4'b0000,
    IC_RISE = 4'b0001,
    IC_FALL = 4'b0010,
    IC_BOTH = 4'b0011,
    IC_RISE4 = 4'b0100,
    IC_RISE16 = 4'b0101
  } ccpt_ic_t;

  localparam logic [3:0] PRESCALE_4 = 4'h3;
  localparam logic [3:0] PRESCALE_16 = 4'hf;
endpackage : ccpt_pkg
`default_nettype wire

// ---- hw/ccpt_capfifo.sv ----
`timescale 1ns/1ps
`default_nettype none
// Small capture FIFO, words of capture values
module ccpt_capfifo #(
  parameter int W = 32,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  input wire logic push_valid_i,
  output logic push_ready_o,
  input wire logic [W-1:0] push_data_i,
  output logic pop_valid_o,
  input wire logic pop_ready_i,
  output logic [W-1:0] pop_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire do_push = push_valid_i && push_ready_o;
  wire do_pop = pop_valid_o && pop_ready_i;

  // Honest full and empty
  assign push_ready_o = (count != (AW+1)'(DEPTH));
  assign pop_valid_o = (count != '0);
  assign pop_data_o = mem[rd_ptr];

  // Storage
  always_ff @(posedge clk_i) begin
    if (do_push) mem[wr_ptr] <= push_data_i;
  end

  // Pointers and fill level
  always_ff @(posedge clk_i) begin
    if (rst_i || flush_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_push) wr_ptr <= wr_ptr + 1'b1;
      if (do_pop) rd_ptr <= rd_ptr + 1'b1;
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule : ccpt_capfifo
`default_nettype wire

// ---- hw/ccpt_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// (RULE_01) Only one major function runs at once
// (RULE_02) Single variant drives one output only
// (RULE_03) Three-bit clock select, code zero system
// (RULE_04) Nonzero sources only for synchronous timer
// (RULE_05) Sync when resync set, trigger clear
// (RULE_06) Software clears resync with system clock
// (RULE_07) Timer mode: capture off, function zero
// (RULE_08) Wide select: dual 16 or single 32
// (RULE_09) Primary low timer owns sync in/out
// (RULE_10) Secondary high timer: periodic event only
// (RULE_11) High half increments on low overflow
// (RULE_12) Software sets wide bit before init
// (RULE_13) Sync input clears timer, then counts
// (RULE_14) Software never picks sync code all-ones
// (RULE_15) Trigger mode holds timer until trigger
// (RULE_16) Trigger clear drops flag, holds zero
// (RULE_17) Trigger only with system clock source
// (RULE_18) Output compare function code decoding
// (RULE_19) Center-aligned only on multi variant
// (RULE_20) Capture stores dedicated timer into FIFO
// (RULE_21) Capture edge mode decoding, wide width
// (RULE_22) Auxiliary output select per mode
// (RULE_23) Counter ticks, clears on period match
module ccpt_top
  import ccpt_pkg::*;
#(
  parameter bit MULTI_OUTPUT = 1'b0,
  parameter int NUM_OUT = 6
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] clk_src_i,
  input wire logic [31:0] sync_src_i,
  input wire logic capture_pin_i,
  output logic sync_out_o,
  output logic secondary_period_o,
  output logic [NUM_OUT-1:0] compare_out_o,
  output logic aux_out_o
);
  // Register state
  logic [15:0] control_one_low;
  logic [15:0] control_one_high;
  logic [15:0] control_two_high;
  logic [HALF_W-1:0] counter_low_half;
  logic [HALF_W-1:0] counter_high_half;
  logic [HALF_W-1:0] period_low_half;
  logic [HALF_W-1:0] period_high_half;
  logic [31:0] primary_compare_value;
  logic [31:0] secondary_compare_value;
  logic [31:0] capture_fifo_output;
  logic triggered_status_flag;
  logic cap_overflow;
  logic compare_level;
  logic [40:0] pin_meta;
  logic [40:0] pin_sync;
  logic [2:0] src_last;

  // Control fields
  wire [3:0] function_code = control_one_low[F_FUNC_LSB +: 4];
  wire capture_function_select = control_one_low[F_CAPSEL];
  wire wide_count_select = control_one_low[F_WIDE];
  wire [2:0] timebase_clock_source_select = control_one_low[F_CLKSEL_LSB +: 3];
  wire timebase_clock_resync = control_one_low[F_RESYNC];
  wire module_on = control_one_low[F_ENABLE];
  wire [4:0] sync_select = control_one_high[F_SYNC_LSB +: 5];
  wire trigger_operation_enable = control_one_high[F_TRIGGER_OPERATION_ENABLE];
  wire [1:0] secondary_output_select = control_two_high[F_AUX_LSB +: 2];

  // Bus decode
  wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire bus_wr = bus_req && wb_we_i && wb_sel_i[0];
  wire wr_ctrl_lo = bus_wr && (wb_adr_i == REG_CTRL_LO);
  wire wr_ctrl_hi = bus_wr && (wb_adr_i == REG_CTRL_HI);
  wire wr_ctrl2 = bus_wr && (wb_adr_i == REG_CTRL2_HI);
  wire wr_status = bus_wr && (wb_adr_i == REG_STATUS);
  wire wr_cnt_lo = bus_wr && (wb_adr_i == REG_CNT_LO);
  wire wr_cnt_hi = bus_wr && (wb_adr_i == REG_CNT_HI);
  wire wr_per_lo = bus_wr && (wb_adr_i == REG_PER_LO);
  wire wr_per_hi = bus_wr && (wb_adr_i == REG_PER_HI);
  wire wr_cmp_a = bus_wr && (wb_adr_i == REG_CMP_A);
  wire wr_cmp_b = bus_wr && (wb_adr_i == REG_CMP_B);
  wire rd_cap_hi = bus_req && !wb_we_i && (wb_adr_i == REG_CAP_HI);
  wire trigger_clear_request = wr_status && wb_dat_i[F_TRIGGER_CLEAR_REQUEST];

  // Mode decode, at most one major function at a time
  wire timer_mode = module_on && !capture_function_select
                    && (function_code == FN_TIMER); // RULE_07 RULE_01
  wire capture_mode = module_on && capture_function_select; // RULE_20 RULE_01
  wire center_ok = MULTI_OUTPUT || (function_code != FN_CENTER); // RULE_19
  wire compare_mode = module_on && !capture_function_select
                      && (function_code != FN_TIMER)
                      && (function_code <= FN_VAR_FREQ) && center_ok; // RULE_18 RULE_01
  wire sync_operation = timebase_clock_resync && !trigger_operation_enable; // RULE_05

  // Source validity: nonzero clocks only for synchronous timer
  wire src_system = (timebase_clock_source_select == CLK_SYSTEM); // RULE_03
  wire cfg_valid = src_system ? !timebase_clock_resync
                   : (timer_mode && sync_operation); // RULE_04 RULE_06 RULE_17
  wire run_ok = module_on && cfg_valid;

  // Two-stage sync of every pin; selection only reads stage two
  wire [31:0] sync_lines = pin_sync[40:9];
  wire [7:0] clk_lines = pin_sync[7:0];
  wire [2:0] src_sync = {sync_lines[sync_select], pin_sync[8],
                         clk_lines[timebase_clock_source_select]};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta <= '0;
      pin_sync <= '0;
      src_last <= '0;
    end else begin
      pin_meta <= {sync_src_i, capture_pin_i, clk_src_i};
      pin_sync <= pin_meta;
      src_last <= src_sync;
    end
  end

  // Time base tick: every system cycle or a rising edge of the source
  wire tick = run_ok && (src_system || (src_sync[0] && !src_last[0])); // RULE_03 RULE_23
  wire sync_in_edge = src_sync[2] && !src_last[2]
                      && (sync_select != SYNC_NONE)
                      && (sync_select != SYNC_AUTO_ROLL); // RULE_14
  wire cap_rise = src_sync[1] && !src_last[1];
  wire cap_fall = !src_sync[1] && src_last[1];

  // Trigger flag: set on trigger, cleared by trigger clear; set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) triggered_status_flag <= 1'b0;
    else if (trigger_operation_enable && sync_in_edge) triggered_status_flag <= 1'b1; // RULE_15
    else if (trigger_clear_request || !trigger_operation_enable)
      triggered_status_flag <= 1'b0; // RULE_16
  end

  // Hold and clear conditions of the primary time base
  wire trig_hold = trigger_operation_enable && !triggered_status_flag; // RULE_15 RULE_16
  wire sync_clear = !trigger_operation_enable && sync_in_edge; // RULE_13
  wire counting = tick && !trig_hold && !capture_mode;

  // Period match of each half and of the joined counter
  wire [31:0] count32 = {counter_high_half, counter_low_half};
  wire [31:0] period32 = {period_high_half, period_low_half};
  wire match32 = (count32 == period32);
  wire match_lo = (counter_low_half == period_low_half);
  wire match_hi = (counter_high_half == period_high_half);
  wire primary_roll = counting && (wide_count_select ? match32 : match_lo); // RULE_23
  wire secondary_roll = counting && !wide_count_select && timer_mode && match_hi; // RULE_10
  wire low_overflow = counting && (counter_low_half == '1); // RULE_11

  // Capture counter keeps counting freely on the system clock
  wire cap_tick = capture_mode && run_ok;

  // Capture event selection with prescaled rising edges
  logic [3:0] rise_count;
  logic cap_event;
  always_comb begin
    unique case (function_code)
      IC_EDGE, IC_BOTH: cap_event = cap_rise || cap_fall; // RULE_21
      IC_RISE: cap_event = cap_rise;
      IC_FALL: cap_event = cap_fall;
      IC_RISE4: cap_event = cap_rise && (rise_count[1:0] == PRESCALE_4[1:0]);
      IC_RISE16: cap_event = cap_rise && (rise_count == PRESCALE_16);
      default: cap_event = 1'b0;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || !capture_mode) rise_count <= '0;
    else if (cap_rise) rise_count <= rise_count + 1'b1;
  end

  // Capture FIFO; a word is narrowed to 16 bits unless wide
  wire [31:0] cap_word = wide_count_select ? count32 : {16'h0000, counter_low_half}; // RULE_21
  wire fifo_ready;
  wire fifo_valid;
  wire [31:0] fifo_data;
  ccpt_capfifo #(.W(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flush_i(!capture_mode),
    .push_valid_i(cap_event && capture_mode),
    .push_ready_o(fifo_ready),
    .push_data_i(cap_word), // RULE_20
    .pop_valid_o(fifo_valid),
    .pop_ready_i(rd_cap_hi),
    .pop_data_o(fifo_data)
  );

  // Overflow flag: set wins over software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) cap_overflow <= 1'b0;
    else if (cap_event && capture_mode && !fifo_ready) cap_overflow <= 1'b1;
    else if (wr_status && wb_dat_i[F_CAP_OVF]) cap_overflow <= 1'b0;
  end

  // Counter halves
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      counter_low_half <= '0;
      counter_high_half <= '0;
    end else if (trig_hold || sync_clear) begin
      counter_low_half <= '0; // RULE_13 RULE_15 RULE_16
      if (wide_count_select || !timer_mode) counter_high_half <= '0;
    end else if (cap_tick) begin
      {counter_high_half, counter_low_half} <= count32 + 32'h1; // RULE_20
    end else begin
      if (wr_cnt_lo) counter_low_half <= wb_dat_i[HALF_W-1:0];
      else if (primary_roll) counter_low_half <= '0; // RULE_23 RULE_09
      else if (counting) counter_low_half <= counter_low_half + 1'b1;
      if (wr_cnt_hi) counter_high_half <= wb_dat_i[HALF_W-1:0];
      else if (wide_count_select) begin
        if (primary_roll) counter_high_half <= '0;
        else if (low_overflow) counter_high_half <= counter_high_half + 1'b1; // RULE_11
      end else if (secondary_roll) counter_high_half <= '0; // RULE_10
      else if (counting && timer_mode) counter_high_half <= counter_high_half + 1'b1; // RULE_08
    end
  end

  // Software registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      control_one_low <= '0;
      control_one_high <= '0;
      control_two_high <= '0;
      period_low_half <= '1;
      period_high_half <= '1;
      primary_compare_value <= '0;
      secondary_compare_value <= '0;
    end else begin
      if (wr_ctrl_lo) control_one_low <= wb_dat_i[15:0];
      if (wr_ctrl_hi) control_one_high <= wb_dat_i[15:0];
      if (wr_ctrl2) control_two_high <= wb_dat_i[15:0];
      if (wr_per_lo) period_low_half <= wb_dat_i[HALF_W-1:0];
      if (wr_per_hi) period_high_half <= wb_dat_i[HALF_W-1:0];
      if (wr_cmp_a) primary_compare_value <= wb_dat_i;
      if (wr_cmp_b) secondary_compare_value <= wb_dat_i;
    end
  end

  // Compare match terms, 32-bit in every compare mode whenever wide is set
  wire [31:0] cmp_view = wide_count_select ? count32 : {16'h0000, counter_low_half};
  wire match_a = counting && (cmp_view == primary_compare_value);
  wire match_b = counting && (cmp_view == secondary_compare_value);

  // Output compare waveform
  logic next_level;
  always_comb begin
    next_level = compare_level;
    if (!compare_mode) next_level = 1'b0;
    else begin
      unique case (function_code)
        FN_OC_HIGH: if (match_a) next_level = 1'b1; // RULE_18
        FN_OC_LOW: if (match_a) next_level = 1'b0;
        FN_OC_TOGGLE: if (match_a) next_level = !compare_level;
        FN_DUAL_EDGE, FN_DUAL_BUF, FN_CENTER: begin
          if (match_b) next_level = 1'b0;
          else if (match_a) next_level = 1'b1;
        end
        FN_VAR_FREQ: if (match_a) next_level = !compare_level;
        default: next_level = 1'b0;
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) compare_level <= 1'b0;
    else compare_level <= next_level;
  end

  // Output drive: single variant has only one active output
  always_ff @(posedge clk_i) begin
    if (rst_i) compare_out_o <= '0;
    else if (MULTI_OUTPUT) compare_out_o <= {NUM_OUT{next_level}}; // RULE_02
    else compare_out_o <= {{(NUM_OUT-1){1'b0}}, next_level}; // RULE_02
  end

  // Sync out only from primary, period event from secondary
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_out_o <= 1'b0;
      secondary_period_o <= 1'b0;
      aux_out_o <= 1'b0;
    end else begin
      sync_out_o <= primary_roll && !capture_mode; // RULE_09
      secondary_period_o <= secondary_roll; // RULE_10
      unique case (secondary_output_select)
        AUX_OFF: aux_out_o <= 1'b0; // RULE_22
        AUX_PERIOD: aux_out_o <= timer_mode ? primary_roll : 1'b0; // RULE_22
        AUX_EVENT: aux_out_o <= compare_mode ? match_a : (capture_mode && cap_event);
        AUX_SIGNAL: aux_out_o <= compare_mode ? next_level : 1'b0;
      endcase
    end
  end

  // Capture read holding register
  always_ff @(posedge clk_i) begin
    if (rst_i) capture_fifo_output <= '0;
    else if (rd_cap_hi && fifo_valid) capture_fifo_output <= fifo_data;
  end

  // Read mux
  wire [31:0] status_word = {24'h0, triggered_status_flag, 4'h0,
                             cap_overflow, !cfg_valid, fifo_valid};
  logic [31:0] rd_mux;
  always_comb begin
    unique case (wb_adr_i)
      REG_CTRL_LO: rd_mux = {16'h0000, control_one_low};
      REG_CTRL_HI: rd_mux = {16'h0000, control_one_high};
      REG_CTRL2_HI: rd_mux = {16'h0000, control_two_high};
      REG_STATUS: rd_mux = status_word;
      REG_CNT_LO: rd_mux = {16'h0000, counter_low_half};
      REG_CNT_HI: rd_mux = {16'h0000, counter_high_half};
      REG_PER_LO: rd_mux = {16'h0000, period_low_half};
      REG_PER_HI: rd_mux = {16'h0000, period_high_half};
      REG_CMP_A: rd_mux = primary_compare_value;
      REG_CMP_B: rd_mux = secondary_compare_value;
      REG_CAP_LO: rd_mux = capture_fifo_output;
      REG_CAP_HI: rd_mux = fifo_data;
      default: rd_mux = 32'h0;
    endcase
  end

  // One-cycle ack for any address; unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req) wb_dat_o <= rd_mux;
    end
  end

  // Checks
  sync_out_secondary_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_10
    secondary_roll && !primary_roll |=> !sync_out_o)
    else $error("secondary roll drove sync output");
  trig_hold_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_15
    trig_hold && !rst_i |=> counter_low_half == '0 || $past(wr_cnt_lo))
    else $error("counter moved while awaiting trigger");
  trig_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_16
    trigger_clear_request && !sync_in_edge |=> !triggered_status_flag)
    else $error("trigger flag not cleared");
  sync_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_13
    sync_clear |=> counter_low_half == '0)
    else $error("sync did not clear counter");
  high_carry_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_11
    low_overflow && wide_count_select && !primary_roll && !wr_cnt_hi && !cap_tick
    && !trig_hold && !sync_clear && module_on
    |=> counter_high_half == $past(counter_high_half) + 16'h1)
    else $error("high half missed carry");
  single_out_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_02
    !MULTI_OUTPUT |-> compare_out_o[NUM_OUT-1:1] == '0)
    else $error("extra output driven");
  capture_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_01
    capture_mode |=> compare_out_o == '0 && !sync_out_o)
    else $error("other function active during capture");
  aux_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_22
    secondary_output_select == AUX_OFF |=> !aux_out_o)
    else $error("aux output active while off");
  ext_src_tick_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_04
    !src_system && !(timer_mode && sync_operation) |-> !tick)
    else $error("invalid source ticked");
endmodule : ccpt_top
`default_nettype wire

// ---- bench/ccpt_peer_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Far side: peer sync pulses, source clocks, capture pin
module ccpt_peer_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [4:0] idx_i,
  input wire logic pin_i,
  output logic [31:0] sync_src_o,
  output logic [7:0] clk_src_o,
  output logic capture_o
);
  logic [2:0] hold = 3'h0;
  logic [4:0] sel = 5'h00;
  logic [7:0] div = 8'h00;
  // Four-cycle pulse so a two-stage sampler cannot miss it
  always @(posedge clk_i) begin
    if (go_i) begin
      sel <= idx_i;
      hold <= 3'h4;
    end else if (hold != 3'h0) begin
      hold <= hold - 3'h1;
    end
    div <= div + 8'h01;
  end
  // One peer line at a time, the rest low
  assign sync_src_o = (hold != 3'h0) ? (32'h1 << sel) : 32'h0;
  // Slow sources, slot zero tied low for the system clock code
  assign clk_src_o = {div[7:1], 1'b0};
  assign capture_o = pin_i;
endmodule : ccpt_peer_model
`default_nettype wire

// ---- bench/tb_ccpt_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the capture/compare timer
module tb_ccpt_top;
  import ccpt_pkg::*;
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin miscompares++; \
  $display("Error %s expected %0h seen %0h", nm, e, s); end end
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, go, pin, ack, so, sp, ax, cap;
  logic [7:0] adr, csrc;
  logic [3:0] sel;
  logic [4:0] idx;
  logic [31:0] dat, q, dat_o, ssrc;
  logic [5:0] co;
  int miscompares = 0;
  int cmp_count = 0;
  int n_so = 0;
  int n_ax = 0;
  always #12.5 clk_i = ~clk_i;
  // Sticky pulse counts
  always @(posedge clk_i) begin
    n_so += (so === 1'b1);
    n_ax += (ax === 1'b1);
  end
  ccpt_top ccpt_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .clk_src_i(csrc), .sync_src_i(ssrc), .capture_pin_i(cap),
    .sync_out_o(so), .secondary_period_o(sp), .compare_out_o(co), .aux_out_o(ax));
  ccpt_peer_model ccpt_peer_model_i (.clk_i(clk_i), .go_i(go), .idx_i(idx), .pin_i(pin),
    .sync_src_o(ssrc), .clk_src_o(csrc), .capture_o(cap));
  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hf};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = dat_o;
    {cyc, stb} <= 2'b00;
    if (n >= 50) miscompares++;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
  endtask : rd
  task automatic reset_dut;
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask : reset_dut
  function automatic logic [31:0] cl(input logic [3:0] f, input logic c, w,
    input logic [2:0] k, input logic r, en);
    return {16'h0, en, 3'h0, r, k, 2'h0, w, c, f};
  endfunction : cl
  task automatic peer(input logic [4:0] i);
    @(posedge clk_i);
    {go, idx} <= {1'b1, i};
    @(posedge clk_i);
    go <= 1'b0;
  endtask : peer
  function automatic logic pk(input int s);
    return s == 0 ? so : (s == 1 ? sp : ax);
  endfunction : pk
  // Cycles between two pulses of one output
  task automatic gap(input int s, output int g);
    for (int n = 0; n < 200 && pk(s) !== 1'b1; n++) @(posedge clk_i);
    @(posedge clk_i);
    for (g = 1; g < 200 && pk(s) !== 1'b1; g++) @(posedge clk_i);
  endtask : gap
  task automatic t_timer;
    int g;
    reset_dut;
    rd(REG_PER_LO);
    `CHK("per_lo", 32'h0000ffff, q)
    rd(REG_CTRL_LO);
    `CHK("ctrl_lo", 32'h0, q)
    rd(8'h3c);
    `CHK("unmapped", 32'h0, q)
    wr(REG_PER_LO, 32'h4);
    wr(REG_PER_HI, 32'h2);
    wr(REG_CTRL2_HI, 32'h8);
    wr(REG_CTRL_LO, cl(FN_TIMER, 0, 0, 0, 0, 1));
    gap(0, g);
    `CHK("sync_gap", 5, g)
    gap(1, g);
    `CHK("sec_gap", 3, g)
    gap(2, g);
    `CHK("aux_gap", 5, g)
    wr(REG_CTRL2_HI, 32'h0);
    @(posedge clk_i) n_ax = 0;
    repeat (30) @(posedge clk_i);
    `CHK("aux_off", 0, n_ax)
  endtask : t_timer
  task automatic t_wide;
    reset_dut;
    wr(REG_CTRL_LO, cl(FN_TIMER, 0, 1, 0, 0, 0));
    wr(REG_CNT_LO, 32'hfff8);
    wr(REG_CNT_HI, 32'h0);
    wr(REG_CTRL_LO, cl(FN_TIMER, 0, 1, 0, 0, 1));
    repeat (30) @(posedge clk_i);
    rd(REG_CNT_HI);
    `CHK("cnt_hi", 16'h0001, q[15:0])
  endtask : t_wide
  task automatic t_sync;
    reset_dut;
    wr(REG_CTRL_HI, 32'h1);
    wr(REG_CTRL_LO, cl(FN_TIMER, 0, 0, 0, 0, 1));
    repeat (100) @(posedge clk_i);
    peer(5'h01);
    repeat (8) @(posedge clk_i);
    rd(REG_CNT_LO);
    `CHK("sync_clear", 1'b1, q[15:0] < 16'h0010)
  endtask : t_sync
  task automatic t_trig;
    reset_dut;
    wr(REG_CTRL_HI, 32'h82);
    wr(REG_CTRL_LO, cl(FN_TIMER, 0, 0, CLK_SYSTEM, 0, 1));
    repeat (20) @(posedge clk_i);
    rd(REG_CNT_LO);
    `CHK("held", 16'h0, q[15:0])
    peer(5'h02);
    repeat (20) @(posedge clk_i);
    rd(REG_STATUS);
    `CHK("trig_flag", 1'b1, q[F_TRIGGED])
    rd(REG_CNT_LO);
    `CHK("running", 1'b1, q[15:0] != 16'h0)
    wr(REG_STATUS, 32'h20);
    repeat (10) @(posedge clk_i);
    rd(REG_CNT_LO);
    `CHK("cleared", 16'h0, q[15:0])
    rd(REG_STATUS);
    `CHK("flag_low", 1'b0, q[F_TRIGGED])
  endtask : t_trig
  // Clock source against operating style
  task automatic t_cfg;
    logic [2:0] k[5] = '{3'h1, 3'h7, 3'h3, 3'h0, 3'h2};
    logic r[5] = '{1, 0, 1, 0, 1};
    logic t[5] = '{0, 0, 1, 0, 0};
    logic c[5] = '{0, 0, 0, 1, 1};
    logic e[5] = '{0, 1, 1, 0, 1};
    for (int i = 0; i < 5; i++) begin
      reset_dut;
      wr(REG_CTRL_HI, {24'h0, t[i], 7'h0});
      wr(REG_CTRL_LO, cl(4'h0, c[i], 0, k[i], r[i], 1));
      repeat (5) @(posedge clk_i);
      rd(REG_STATUS);
      `CHK("cfg_bad", e[i], q[F_CFG_BAD])
    end
  endtask : t_cfg
  task automatic oc(input logic [3:0] f, input int hi_e, ch_e);
    int hi, ch, bad, axd;
    logic p;
    if (f != FN_OC_LOW) reset_dut;
    wr(REG_PER_LO, 32'h9);
    wr(REG_CMP_A, 32'h2);
    wr(REG_CMP_B, 32'h6);
    wr(REG_CTRL2_HI, {27'h0, AUX_SIGNAL, 3'h0});
    wr(REG_CTRL_LO, cl(f, 0, 0, 0, 0, 1));
    repeat (40) @(posedge clk_i);
    {hi, ch, bad, axd} = '0;
    p = co[0];
    repeat (20) begin
      @(posedge clk_i);
      hi += (co[0] === 1'b1);
      ch += (co[0] !== p);
      bad += (co[5:1] !== 5'h0);
      axd += (ax !== co[0]);
      p = co[0];
    end
    `CHK("extra_out", 0, bad)
    `CHK("aux_sig", 0, axd)
    if (hi_e >= 0) `CHK("oc_high", hi_e, hi)
    if (ch_e >= 0) `CHK("oc_edges", ch_e, ch)
  endtask : oc
  task automatic cap_run(input logic [3:0] f, input int n, e);
    logic [31:0] v[4];
    int got;
    reset_dut;
    wr(REG_CTRL_LO, cl(f, 1, 0, 0, 0, 1));
    n_so = 0;
    repeat (n) begin
      pin <= 1'b1;
      repeat (5) @(posedge clk_i);
      pin <= 1'b0;
      repeat (15) @(posedge clk_i);
    end
    repeat (10) @(posedge clk_i);
    got = 0;
    rd(REG_STATUS);
    while (q[F_CAP_AVAIL] === 1'b1 && got < 4) begin
      rd(REG_CAP_HI);
      v[got] = q;
      got++;
      rd(REG_STATUS);
    end
    `CHK("captures", e, got)
    if (f == IC_RISE && got == 2) `CHK("cap_diff", 32'd20, v[1] - v[0])
    `CHK("sync_quiet", 0, n_so)
  endtask : cap_run
  task automatic end_of_test;
    if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    {cyc, stb, we, adr, dat, sel, go, idx, pin} = '0;
    t_timer;
    t_wide;
    t_sync;
    t_trig;
    t_cfg;
    oc(FN_OC_HIGH, 20, 0);
    oc(FN_OC_LOW, 0, 0);
    oc(FN_OC_TOGGLE, 10, 2);
    oc(FN_DUAL_EDGE, 8, 4);
    oc(FN_DUAL_BUF, 8, 4);
    oc(FN_CENTER, 0, 0);
    oc(FN_VAR_FREQ, -1, -1);
    cap_run(IC_EDGE, 1, 2);
    cap_run(IC_RISE, 2, 2);
    cap_run(IC_FALL, 1, 1);
    cap_run(IC_BOTH, 1, 2);
    cap_run(IC_RISE4, 3, 0);
    cap_run(IC_RISE4, 4, 1);
    cap_run(IC_RISE16, 16, 1);
    end_of_test;
  end
  // Watchdog well past the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    end_of_test;
  end
endmodule : tb_ccpt_top
`default_nettype wire
